/* cbid_pkg.sv */
`default_nettype none
package cbid_pkg;
	// operation codes
	typedef enum logic [3:0] {
		CBID_OP_NONE   = 4'h0,
		CBID_OP_DECADD = 4'h1, // decimal_add
		CBID_OP_SUB1   = 4'h2, // subtract_one
		CBID_OP_SUB2   = 4'h3, // subtract_two
		CBID_OP_ADD1   = 4'h4, // add_one
		CBID_OP_ADD2   = 4'h5, // add_two
		CBID_OP_CPL    = 4'h6, // bitwise_complement
		CBID_OP_IRQDIS = 4'h7, // global_irq_disable
		CBID_OP_IRQEN  = 4'h8  // global_irq_enable_op
	} cbid_op_e;

	// status_word bit positions
	localparam int SW_C        = 0;
	localparam int SW_Z        = 1;
	localparam int SW_N        = 2;
	localparam int SW_IRQEN    = 3; // global_irq_enable
	localparam int SW_CORE_OFF = 4; // core_off_bit
	localparam int SW_OSC_OFF  = 5; // oscillator_off_bit
	localparam int SW_V        = 8;
	localparam logic [15:0] SW_IRQEN_MASK = 16'h0008;
	localparam logic [15:0] SW_RESET    = 16'h0000;

	// ahb register map (byte addresses)
	localparam logic [7:0] A_CTRL   = 8'h00; // w: op[3:0], byte[4], go[8]
	localparam logic [7:0] A_SRC    = 8'h04;
	localparam logic [7:0] A_DST    = 8'h08;
	localparam logic [7:0] A_RES    = 8'h0c; // r: result
	localparam logic [7:0] A_SW     = 8'h10; // rw: status_word
	localparam logic [7:0] A_IRQ    = 8'h14; // r: irq_accept_ok[0]
	localparam int CTRL_BYTE = 4;
	localparam int CTRL_GO   = 8;

	// one operation request
	typedef struct packed {
		cbid_op_e    op;
		logic        byte_mode;
		logic [15:0] src;
		logic [15:0] dst;
	} cbid_req_s;
endpackage : cbid_pkg
`default_nettype wire

/* cbid_core.sv */
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// overview
// ==========================================
// Overview of operation
// - decimal_add operands are packed bcd digits
// - decimal_add sums source, destination and carry
// - carry set when decimal sum overflows width
// - decimal_add: n from msb, z zero, v undefined
// - subtract_one: z if dst 1, c unless 0
// - subtract_one overflow only at most negative value
// - subtract_two: z if dst 2, c unless 0/1
// - subtract_two overflow at two most negative values
// - increments, decrements, complement set n from sign
// - global_irq_disable clears only enable bit
// - interrupt still accepted one boundary after disable
// - global_irq_enable_op sets enable, flags untouched
// - instruction after enable runs before interrupt
// - mode bits untouched by these operations
// - add_one: c and z when dst all ones
// - add_one overflow only at largest positive value
// - add_two carry at top two, z at fe
// - add_two overflow at two largest positive values
// - bitwise_complement is xor with all ones
module cbid_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hsel,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq_accept_ok_o, // core may take an interrupt at this boundary
	output logic      [15:0] status_word_o
);
	// ==========================================
	// bus address phase capture
	// ==========================================
	logic        wr_pend_r;  // write data phase pending
	logic [7:0]  addr_r;     // captured address
	logic        acc;        // valid access
	assign acc       = hsel && hready && htrans[1];
	assign hreadyout = 1'b1; // zero wait states
	assign hresp     = 1'b0; // always okay

	// address phase capture; write data follows one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end else begin
			wr_pend_r <= acc && hwrite;
			if (acc) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	// ==========================================
	// request registers
	// ==========================================
	cbid_pkg::cbid_req_s req_r;   // operation request
	logic                go;      // start pulse from ctrl write
	assign go = wr_pend_r && (addr_r == cbid_pkg::A_CTRL) && hwdata[cbid_pkg::CTRL_GO];

	// operand and operation registers, written in the data phase
	// go acts on the op latched by an earlier control write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_r <= '{op: cbid_pkg::CBID_OP_NONE, byte_mode: 1'b0, src: 16'h0000, dst: 16'h0000};
		end else if (wr_pend_r) begin
			unique case (addr_r)
				cbid_pkg::A_CTRL: begin
					req_r.op        <= cbid_pkg::cbid_op_e'(hwdata[3:0]);
					req_r.byte_mode <= hwdata[cbid_pkg::CTRL_BYTE];
				end
				cbid_pkg::A_SRC: req_r.src <= hwdata[15:0];
				cbid_pkg::A_DST: req_r.dst <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// datapath
	// ==========================================
	logic [15:0] sw_r;      // status_word
	logic [15:0] res_r;     // last result
	logic [15:0] d;         // operand, byte form masked
	logic [15:0] s;         // source, byte form masked
	logic [15:0] res;       // combinational result
	logic [15:0] msk;       // width mask
	logic        bm;        // byte mode
	logic        c_n, z_n, n_n, v_n;
	logic        bcd_c;     // decimal carry chain
	logic [4:0]  dig;       // one digit sum
	logic [15:0] top;       // sign bit mask

	// one combinational pass gives result and next flags
	// byte form masks operands first, so bit 7 is the sign
	always_comb begin
		bm    = req_r.byte_mode;
		msk   = bm ? 16'h00ff : 16'hffff;
		top   = bm ? 16'h0080 : 16'h8000;
		d     = req_r.dst & msk;
		s     = req_r.src & msk;
		res   = d;
		c_n   = sw_r[cbid_pkg::SW_C];
		z_n   = sw_r[cbid_pkg::SW_Z];
		n_n   = sw_r[cbid_pkg::SW_N];
		v_n   = sw_r[cbid_pkg::SW_V];
		bcd_c = sw_r[cbid_pkg::SW_C];
		dig   = 5'h00;
		unique case (req_r.op)
			cbid_pkg::CBID_OP_DECADD: begin
				// digit-wise bcd add with carry
				for (int i = 0; i < 4; i++) begin
					dig = {1'b0, d[i*4 +: 4]} + {1'b0, s[i*4 +: 4]} + {4'h0, bcd_c};
					if (dig > 5'h09) begin
						dig = dig + 5'h06;
					end
					res[i*4 +: 4] = dig[3:0];
					bcd_c = dig[4];
					if (bm && i == 1) begin
						break;
					end
				end
				res = res & msk;
				c_n = bcd_c;
				v_n = sw_r[cbid_pkg::SW_V];     // undefined: left as is
			end
			cbid_pkg::CBID_OP_SUB1: begin
				res = (d - 16'h0001) & msk;
				c_n = (d != 16'h0000);
				v_n = (d == top);
			end
			cbid_pkg::CBID_OP_SUB2: begin
				res = (d - 16'h0002) & msk;
				c_n = (d > 16'h0001);
				v_n = (d == top) || (d == (top | 16'h0001));
			end
			cbid_pkg::CBID_OP_ADD1: begin
				res = (d + 16'h0001) & msk;
				c_n = (d == msk);
				v_n = (d == (top - 16'h0001));
			end
			cbid_pkg::CBID_OP_ADD2: begin
				res = (d + 16'h0002) & msk;
				c_n = (d >= (msk - 16'h0001));
				v_n = (d == (top - 16'h0001)) || (d == (top - 16'h0002));
			end
			cbid_pkg::CBID_OP_CPL: begin
				res = d ^ msk;
				c_n = (res != 16'h0000);
				v_n = ((d & top) != 16'h0000);
			end
			default: ;
		endcase
		n_n = ((res & top) != 16'h0000);
		z_n = (res == 16'h0000);
	end

	// operations that touch the result and the arithmetic flags
	logic is_arith;
	assign is_arith = (req_r.op inside {cbid_pkg::CBID_OP_DECADD, cbid_pkg::CBID_OP_SUB1,
		cbid_pkg::CBID_OP_SUB2, cbid_pkg::CBID_OP_ADD1, cbid_pkg::CBID_OP_ADD2, cbid_pkg::CBID_OP_CPL});

	// status word and result update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_r  <= cbid_pkg::SW_RESET;
			res_r <= 16'h0000;
		end else if (go) begin
			if (is_arith) begin
				// only arithmetic flags change; mode bits kept
				res_r <= res;
				sw_r[cbid_pkg::SW_C] <= c_n;
				sw_r[cbid_pkg::SW_Z] <= z_n;
				sw_r[cbid_pkg::SW_N] <= n_n;
				sw_r[cbid_pkg::SW_V] <= v_n;
			end else if (req_r.op == cbid_pkg::CBID_OP_IRQDIS) begin
				sw_r <= sw_r & ~cbid_pkg::SW_IRQEN_MASK;
			end else if (req_r.op == cbid_pkg::CBID_OP_IRQEN) begin
				sw_r <= sw_r | cbid_pkg::SW_IRQEN_MASK;
			end
		end else if (wr_pend_r && addr_r == cbid_pkg::A_SW) begin
			sw_r <= hwdata[15:0];
		end
	end

	// ==========================================
	// interrupt boundary timing
	// ==========================================
	// after enable: next instruction runs first, so hold off one go
	// after disable: old enable still honoured for one boundary
	logic hold_r;  // block acceptance until next instruction completes
	logic late_r;  // enable still in effect one boundary after disable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_r <= 1'b0;
			late_r <= 1'b0;
		end else if (go) begin
			hold_r <= (req_r.op == cbid_pkg::CBID_OP_IRQEN);
			late_r <= (req_r.op == cbid_pkg::CBID_OP_IRQDIS) && sw_r[cbid_pkg::SW_IRQEN];
		end
	end
	assign irq_accept_ok_o = ((sw_r[cbid_pkg::SW_IRQEN] && !hold_r) || late_r);
	assign status_word_o   = sw_r;

	// ==========================================
	// read data
	// ==========================================
	// read mux on the address captured in the address phase
	// zero wait states, so it stands through the whole data phase
	always_comb begin
		hrdata = 32'h0000_0000;
		unique case (addr_r)
			cbid_pkg::A_CTRL: hrdata = {27'h0, req_r.byte_mode, req_r.op};
			cbid_pkg::A_SRC:  hrdata = {16'h0000, req_r.src};
			cbid_pkg::A_DST:  hrdata = {16'h0000, req_r.dst};
			cbid_pkg::A_RES:  hrdata = {16'h0000, res_r};
			cbid_pkg::A_SW:   hrdata = {16'h0000, sw_r};
			cbid_pkg::A_IRQ:  hrdata = {31'h0, irq_accept_ok_o};
			default:          hrdata = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// assertions
	// ==========================================
	property p_dis_clears;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQDIS |=> !sw_r[cbid_pkg::SW_IRQEN];
	endproperty
	a_dis_clears: assert property (p_dis_clears) else $error("irq enable not cleared");

	property p_en_sets;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQEN |=> sw_r[cbid_pkg::SW_IRQEN] && !irq_accept_ok_o;
	endproperty
	a_en_sets: assert property (p_en_sets) else $error("enable timing wrong");

	property p_mode_kept;
		@(posedge clk_i) disable iff (rst_i)
		go && is_arith |=> sw_r[cbid_pkg::SW_IRQEN] == $past(sw_r[cbid_pkg::SW_IRQEN])
			&& sw_r[cbid_pkg::SW_CORE_OFF] == $past(sw_r[cbid_pkg::SW_CORE_OFF])
			&& sw_r[cbid_pkg::SW_OSC_OFF] == $past(sw_r[cbid_pkg::SW_OSC_OFF]);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("mode bit changed");

	property p_sub1_v;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_SUB1 |=> sw_r[cbid_pkg::SW_V] == ($past(d) == $past(top));
	endproperty
	a_sub1_v: assert property (p_sub1_v) else $error("sub1 overflow wrong");

	property p_add1_cz;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_ADD1 && d == msk |=> sw_r[cbid_pkg::SW_C] && sw_r[cbid_pkg::SW_Z];
	endproperty
	a_add1_cz: assert property (p_add1_cz) else $error("add1 wrap flags wrong");

	property p_cpl;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_CPL |=> res_r == ($past(d) ^ $past(msk));
	endproperty
	a_cpl: assert property (p_cpl) else $error("complement wrong");

	property p_byte_hi;
		@(posedge clk_i) disable iff (rst_i)
		go && is_arith && bm |=> res_r[15:8] == 8'h00;
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("byte result high bits set");

	property p_sub2_c;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_SUB2 && d < 16'h0002 |=> !sw_r[cbid_pkg::SW_C];
	endproperty
	a_sub2_c: assert property (p_sub2_c) else $error("sub2 carry wrong");

	property p_late;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQDIS && sw_r[cbid_pkg::SW_IRQEN] |=> irq_accept_ok_o;
	endproperty
	a_late: assert property (p_late) else $error("late accept missing");

	// ==========================================
	// flag checks against fixed thresholds, the stored result and the prior status word
	// ==========================================
	// binary value of the decimal sum, used only to judge the carry
	logic [15:0] chk_dsum;   // operand digits plus carry, as a number
	logic        chk_bcd_ok; // every operand digit is 0..9
	always_comb begin
		chk_dsum = 16'(d[15:12]) * 16'h03e8 + 16'(d[11:8]) * 16'h0064 + 16'(d[7:4]) * 16'h000a + 16'(d[3:0])
			+ 16'(s[15:12]) * 16'h03e8 + 16'(s[11:8]) * 16'h0064 + 16'(s[7:4]) * 16'h000a + 16'(s[3:0])
			+ 16'(sw_r[cbid_pkg::SW_C]);
		chk_bcd_ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (d[i*4 +: 4] > 4'h9 || s[i*4 +: 4] > 4'h9) begin
				chk_bcd_ok = 1'b0;
			end
		end
	end

	property p_decadd_c;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_DECADD && chk_bcd_ok
			|=> sw_r[cbid_pkg::SW_C] == ($past(chk_dsum) > ($past(bm) ? 16'h0063 : 16'h270f));
	endproperty
	a_decadd_c: assert property (p_decadd_c) else $error("decimal carry wrong");

	property p_decadd_v;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_DECADD
			|=> sw_r[cbid_pkg::SW_V] == $past(sw_r[cbid_pkg::SW_V]);
	endproperty
	a_decadd_v: assert property (p_decadd_v) else $error("decimal overflow flag moved");

	property p_sub1_cz;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_SUB1 |=> sw_r[cbid_pkg::SW_Z] == ($past(d) == 16'h0001)
			&& sw_r[cbid_pkg::SW_C] == ($past(d) != 16'h0000);
	endproperty
	a_sub1_cz: assert property (p_sub1_cz) else $error("sub1 zero or carry wrong");

	property p_sub2_v;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_SUB2 |=> sw_r[cbid_pkg::SW_V] == ($past(bm)
			? ($past(d) == 16'h0080 || $past(d) == 16'h0081) : ($past(d) == 16'h8000 || $past(d) == 16'h8001));
	endproperty
	a_sub2_v: assert property (p_sub2_v) else $error("sub2 overflow wrong");

	property p_add1_v;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_ADD1
			|=> sw_r[cbid_pkg::SW_V] == ($past(bm) ? ($past(d) == 16'h007f) : ($past(d) == 16'h7fff));
	endproperty
	a_add1_v: assert property (p_add1_v) else $error("add1 overflow wrong");

	property p_add2_cz;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_ADD2
			|=> sw_r[cbid_pkg::SW_C] == ($past(bm) ? ($past(d) >= 16'h00fe) : ($past(d) >= 16'hfffe))
			&& sw_r[cbid_pkg::SW_Z] == ($past(bm) ? ($past(d) == 16'h00fe) : ($past(d) == 16'hfffe));
	endproperty
	a_add2_cz: assert property (p_add2_cz) else $error("add2 carry or zero wrong");

	property p_add2_v;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_ADD2 |=> sw_r[cbid_pkg::SW_V] == ($past(bm)
			? ($past(d) == 16'h007e || $past(d) == 16'h007f) : ($past(d) == 16'h7ffe || $past(d) == 16'h7fff));
	endproperty
	a_add2_v: assert property (p_add2_v) else $error("add2 overflow wrong");

	property p_nz;
		@(posedge clk_i) disable iff (rst_i)
		go && is_arith |=> sw_r[cbid_pkg::SW_N] == ($past(bm) ? res_r[7] : res_r[15])
			&& sw_r[cbid_pkg::SW_Z] == (res_r == 16'h0000);
	endproperty
	a_nz: assert property (p_nz) else $error("sign or zero flag wrong");

	property p_en_flags;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQEN
			|=> (sw_r & ~cbid_pkg::SW_IRQEN_MASK) == ($past(sw_r) & ~cbid_pkg::SW_IRQEN_MASK);
	endproperty
	a_en_flags: assert property (p_en_flags) else $error("enable touched other bits");

	property p_dis_keep;
		@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQDIS
			|=> (sw_r & ~cbid_pkg::SW_IRQEN_MASK) == ($past(sw_r) & ~cbid_pkg::SW_IRQEN_MASK);
	endproperty
	a_dis_keep: assert property (p_dis_keep) else $error("disable touched other bits");

	c_decadd: cover property (@(posedge clk_i) disable iff (rst_i) go && req_r.op == cbid_pkg::CBID_OP_DECADD);
	c_en:     cover property (@(posedge clk_i) disable iff (rst_i) go && req_r.op == cbid_pkg::CBID_OP_IRQEN);
	c_v:      cover property (@(posedge clk_i) disable iff (rst_i) go && is_arith ##1 sw_r[cbid_pkg::SW_V]);
	c_dis:    cover property (@(posedge clk_i) disable iff (rst_i)
		go && req_r.op == cbid_pkg::CBID_OP_IRQDIS && sw_r[cbid_pkg::SW_IRQEN]);
	c_byte:   cover property (@(posedge clk_i) disable iff (rst_i) go && is_arith && bm);
endmodule : cbid_core
`default_nettype wire

/* cpu_bcd_incdec_flag_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bcd_incdec_flag_logic_test;
	// ==========================================
	// stimulus and observed signals
	// ==========================================
	logic        clk_i   = 1'b0;  // 200 mhz core clock
	logic        rst_i   = 1'b1;  // sync reset, held at start
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;  // whole words only
	logic [31:0] hwdata  = 32'h0;
	logic        hsel    = 1'b0;
	wire  logic  hready;           // single slave drives the bus ready
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq_ok;           // interrupt may be taken now
	logic [15:0] sw_port;          // registered status word
	logic [31:0] rd;               // last read data
	int          bad_count  = 0;
	int          num_checks = 0;

	assign hready = hreadyout;

	cbid_core uut (.clk_i(clk_i), .rst_i(rst_i), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_accept_ok_o(irq_ok), .status_word_o(sw_port));

	// clock toggles every half period
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// ==========================================
	// shared tasks
	// ==========================================
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one single ahb transfer; read data kept in rd
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsel   <= 1'b1;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer

	// preset status, load operands, latch op, then fire it and read result
	task op_case(input string nm, input cbid_pkg::cbid_op_e op, input logic bm, input logic [15:0] s,
		input logic [15:0] d, input logic [15:0] pre, input logic [15:0] res, input logic [15:0] esw,
		input logic [15:0] msk);
		logic [31:0] rm;
		rm = bm ? 32'h0000_00ff : 32'h0000_ffff;  // byte form judged on low byte only
		xfer(1'b1, cbid_pkg::A_SW, {16'h0, pre});
		xfer(1'b1, cbid_pkg::A_SRC, {16'h0, s});
		xfer(1'b1, cbid_pkg::A_DST, {16'h0, d});
		xfer(1'b1, cbid_pkg::A_CTRL, {27'h0, bm, op});
		xfer(1'b1, cbid_pkg::A_CTRL, {23'h0, 1'b1, 3'h0, bm, op});
		xfer(1'b0, cbid_pkg::A_RES, 32'h0);
		check({nm, " result"}, {16'h0, res} & rm, rd & rm);
		xfer(1'b0, cbid_pkg::A_SW, 32'h0);
		check({nm, " status"}, {16'h0, esw & msk}, rd & {16'h0, msk});
	endtask : op_case

	// ==========================================
	// scenarios
	// ==========================================
	task t_reset_and_map;
		check("status after reset", 32'h0, {16'h0, sw_port});
		check("accept after reset", 32'h0, {31'h0, irq_ok});
		check("okay response", 32'h0, {31'h0, hresp});
		xfer(1'b1, 8'h20, 32'hffff_ffff);  // unmapped write is dropped
		xfer(1'b0, 8'h20, 32'h0);
		check("unmapped read", 32'h0, rd);
	endtask : t_reset_and_map

	task t_arith;
		op_case("decadd w", cbid_pkg::CBID_OP_DECADD, 1'b0, 16'h1234, 16'h8765, 16'h0039, 16'h0000, 16'h003b, 16'h003f);
		op_case("decadd b", cbid_pkg::CBID_OP_DECADD, 1'b1, 16'h0045, 16'h7754, 16'h0138, 16'h0099, 16'h003c, 16'h003f);
		op_case("sub1 w", cbid_pkg::CBID_OP_SUB1, 1'b0, 16'h0, 16'h8000, 16'h0038, 16'h7fff, 16'h0139, 16'h013f);
		op_case("sub1 b", cbid_pkg::CBID_OP_SUB1, 1'b1, 16'h0, 16'h1200, 16'h013b, 16'h00ff, 16'h003c, 16'h013f);
		op_case("sub1 1", cbid_pkg::CBID_OP_SUB1, 1'b0, 16'h0, 16'h0001, 16'h013c, 16'h0000, 16'h003b, 16'h013f);
		op_case("sub2 w", cbid_pkg::CBID_OP_SUB2, 1'b0, 16'h0, 16'h8001, 16'h0038, 16'h7fff, 16'h0139, 16'h013f);
		op_case("sub2 b", cbid_pkg::CBID_OP_SUB2, 1'b1, 16'h0, 16'h0001, 16'h013b, 16'h00ff, 16'h003c, 16'h013f);
		op_case("sub2 2", cbid_pkg::CBID_OP_SUB2, 1'b1, 16'h0, 16'h0002, 16'h013c, 16'h0000, 16'h003b, 16'h013f);
		op_case("add1 w", cbid_pkg::CBID_OP_ADD1, 1'b0, 16'h0, 16'hffff, 16'h013c, 16'h0000, 16'h003b, 16'h013f);
		op_case("add1 b", cbid_pkg::CBID_OP_ADD1, 1'b1, 16'h0, 16'h007f, 16'h003b, 16'h0080, 16'h013c, 16'h013f);
		op_case("add2 w", cbid_pkg::CBID_OP_ADD2, 1'b0, 16'h0, 16'hfffe, 16'h013c, 16'h0000, 16'h003b, 16'h013f);
		op_case("add2 b", cbid_pkg::CBID_OP_ADD2, 1'b1, 16'h0, 16'h00ff, 16'h013e, 16'h0001, 16'h0039, 16'h013f);
		op_case("add2 v", cbid_pkg::CBID_OP_ADD2, 1'b0, 16'h0, 16'h7ffe, 16'h003b, 16'h8000, 16'h013c, 16'h013f);
		op_case("cpl w", cbid_pkg::CBID_OP_CPL, 1'b0, 16'h0, 16'h00ae, 16'h0038, 16'hff51, 16'h003c, 16'h003c);
		op_case("cpl b", cbid_pkg::CBID_OP_CPL, 1'b1, 16'h0, 16'h0080, 16'h003c, 16'h007f, 16'h0038, 16'h003c);
	endtask : t_arith

	// disable clears only the enable bit; one more boundary stays open
	task t_irq_disable;
		// result register keeps the last arithmetic result
		op_case("dis", cbid_pkg::CBID_OP_IRQDIS, 1'b0, 16'h0, 16'h0, 16'h013f, 16'h007f, 16'h0137, 16'hffff);
		check("accept after disable", 32'h1, {31'h0, irq_ok});
		xfer(1'b0, cbid_pkg::A_IRQ, 32'h0);
		check("accept register", 32'h1, rd);
		op_case("dis next", cbid_pkg::CBID_OP_CPL, 1'b0, 16'h0, 16'h0, 16'h0137, 16'hffff, 16'h0034, 16'h003c);
		check("accept after next", 32'h0, {31'h0, irq_ok});
	endtask : t_irq_disable

	// enable sets the bit but the following operation runs first
	task t_irq_enable;
		op_case("en", cbid_pkg::CBID_OP_IRQEN, 1'b0, 16'h0, 16'h0, 16'h0131, 16'hffff, 16'h0139, 16'hffff);
		check("accept after enable", 32'h0, {31'h0, irq_ok});
		op_case("en next", cbid_pkg::CBID_OP_ADD1, 1'b0, 16'h0, 16'h0001, 16'h0139, 16'h0002, 16'h0038, 16'h003f);
		check("accept after next", 32'h1, {31'h0, irq_ok});
	endtask : t_irq_enable

	// reset in mid-run clears status, result and the acceptance window
	task t_mid_reset;
		xfer(1'b1, cbid_pkg::A_SW, 32'h0000_013f);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("status after mid reset", 32'h0, {16'h0, sw_port});
		check("accept after mid reset", 32'h0, {31'h0, irq_ok});
		xfer(1'b0, cbid_pkg::A_RES, 32'h0);
		check("result after mid reset", 32'h0, rd);
	endtask : t_mid_reset

	// ==========================================
	// run control
	// ==========================================
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		t_reset_and_map();
		t_arith();
		t_irq_disable();
		t_irq_enable();
		t_mid_reset();
		test_done();
	end

	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		bad_count++;
		test_done();
	end
endmodule : cpu_bcd_incdec_flag_logic_test
`default_nettype wire
